// *** shared/configurable_logic_defines.svh ***
`ifndef CONFIGURABLE_LOGIC_DEFINES_SVH
`define CONFIGURABLE_LOGIC_DEFINES_SVH

// Register offsets
`define CL_OFF_GLOBAL      4'h0
`define CL_OFF_SEQ         4'h1
`define CL_OFF_TABLE0_A    4'h5
`define CL_TABLE_STRIDE    4'h4
`define CL_SUB_A           4'h0
`define CL_SUB_B           4'h1
`define CL_SUB_C           4'h2
`define CL_SUB_PATTERN     4'h3

// Reset value and writable bits
`define CL_RESET_VALUE     8'h00
`define CL_GLOBAL_MASK     8'h41
`define CL_SEQ_MASK        8'h0f
`define CL_CTRL_A_MASK     8'hf9
`define CL_CTRL_C_MASK     8'h0f

// Field positions
`define CL_BIT_ENABLE      0
`define CL_BIT_RUN_STBY    6
`define CL_BIT_EDGE        7
`define CL_BIT_CLOCK_SOURCE_SELECT      6
`define CL_FILT_HI         5
`define CL_FILT_LO         4
`define CL_BIT_PIN_OUTPUT_ENABLE       3
`define CL_SEL1_HI         7
`define CL_SEL1_LO         4
`define CL_SEL0_HI         3
`define CL_SEL0_LO         0

// Sequencer codes
`define CL_SEQ_OFF         4'h0
`define CL_SEQ_DFF         4'h1
`define CL_SEQ_JK          4'h2
`define CL_SEQ_DLATCH      4'h3
`define CL_SEQ_RS          4'h4

// Filter codes
`define CL_FILT_NONE       2'h0
`define CL_FILT_SYNC       2'h1
`define CL_FILT_FULL       2'h2

// Input source codes
`define CL_SRC_MASK        4'h0
`define CL_SRC_FEEDBACK    4'h1
`define CL_SRC_LINK        4'h2
`define CL_SRC_EVENT_LINE_0      4'h3
`define CL_SRC_EVENT_LINE_1      4'h4
`define CL_SRC_PIN         4'h5
`define CL_SRC_COMPARATOR  4'h6
`define CL_SRC_TIMER_B     4'h7
`define CL_SRC_TIMER_A     4'h8
`define CL_SRC_TIMER_D     4'h9
`define CL_SRC_SERIAL      4'ha
`define CL_SRC_SPI         4'hb

`endif

// *** shared/configurable_logic_pkg.sv ***
package configurable_logic_pkg;

  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_DFF,
    SEQ_JK,
    SEQ_DLATCH,
    SEQ_RS,
    SEQ_RESERVED
  } seq_mode_t;

  typedef enum logic [1:0] {
    FILT_NONE,
    FILT_SYNC,
    FILT_FULL,
    FILT_RESERVED
  } filt_mode_t;

endpackage

// *** logic/configurable_logic.sv ***
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "configurable_logic_defines.svh"

module configurable_logic
  import configurable_logic_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_I,
  // Register port
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // Sleep state
  input  wire logic       SLEEP_STANDBY_I,
  // Input sources
  input  wire logic       EVENT_LINE_0_I,
  input  wire logic       EVENT_LINE_1_I,
  input  wire logic [2:0] TABLE0_PIN_I,
  input  wire logic [2:0] TABLE1_PIN_I,
  input  wire logic       COMPARATOR_OUTPUT_I,
  input  wire logic       TIMER_B_OUTPUT_I,
  input  wire logic [2:0] TIMER_A_OUTPUT_I,
  input  wire logic       TIMER_D_OUTPUT_A_I,
  input  wire logic       TIMER_D_OUTPUT_B_I,
  input  wire logic       SERIAL_PORT_TXD_I,
  input  wire logic       USART_CLOCK_I,
  input  wire logic       SPI_SCK_I,
  input  wire logic       SPI_MOSI_I,
  input  wire logic       SPI_MISO_I,
  // Table outputs
  output logic      [1:0] TABLE_OUT_O,
  output logic      [1:0] LUT_PIN_OUTPUT_O,
  output logic      [1:0] LUT_PIN_OE_O
);

  // Register storage
  logic [7:0] global_q;
  logic [3:0] seq_sel_q;
  logic [7:0] ctrl_a_q   [2];
  logic [7:0] ctrl_b_q   [2];
  logic [7:0] ctrl_c_q   [2];
  logic [7:0] pattern_q  [2];
  logic [7:0] rdata_q;

  // Datapath state
  logic [1:0] direct_q;
  logic [1:0] in2_prev_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] hist0_q;
  logic [1:0] hist1_q;
  logic [1:0] filt_q;
  logic [1:0] edge_prev_q;
  logic [1:0] edge_q;
  logic       seq_q;
  logic       seq_hold_q;
  logic [1:0] out_q;

  // Combinational values
  logic        glob_en;
  logic        peripheral_clock_run;
  logic        standby_off;
  logic [1:0]  tab_en;
  logic [1:0]  clock_source_select;
  logic [1:0]  edge_en;
  logic [1:0]  tick;
  logic [1:0]  direct;
  logic [1:0]  filt_out;
  logic [1:0]  stage;
  logic [1:0]  result;
  logic [2:0]  in_v     [2];
  logic [15:0] src_v    [2][3];
  logic [3:0]  sel      [2][3];
  filt_mode_t  fmode    [2];
  seq_mode_t   smode;
  logic        seq_on;
  logic        seq_val;

  function automatic logic [3:0] table_addr(input logic t, input logic [3:0] sub);
    return `CL_OFF_TABLE0_A + (t ? `CL_TABLE_STRIDE : 4'h0) + sub;
  endfunction

  function automatic logic pick(input logic [15:0] vec, input logic [3:0] s);
    return vec[s];
  endfunction

  function automatic filt_mode_t filt_decode(input logic [1:0] f);
    filt_mode_t m;
    m = FILT_RESERVED;
    if (f == `CL_FILT_NONE) m = FILT_NONE;
    if (f == `CL_FILT_SYNC) m = FILT_SYNC;
    if (f == `CL_FILT_FULL) m = FILT_FULL;
    return m;
  endfunction

  function automatic seq_mode_t seq_decode(input logic [3:0] s);
    seq_mode_t m;
    m = SEQ_RESERVED;
    if (s == `CL_SEQ_OFF) m = SEQ_OFF;
    if (s == `CL_SEQ_DFF) m = SEQ_DFF;
    if (s == `CL_SEQ_JK) m = SEQ_JK;
    if (s == `CL_SEQ_DLATCH) m = SEQ_DLATCH;
    if (s == `CL_SEQ_RS) m = SEQ_RS;
    return m;
  endfunction

  assign glob_en     = global_q[`CL_BIT_ENABLE];
  assign standby_off = SLEEP_STANDBY_I & ~global_q[`CL_BIT_RUN_STBY];
  assign peripheral_clock_run = ~standby_off;
  assign smode       = seq_decode(seq_sel_q);
  assign seq_on      = (smode != SEQ_OFF) && (smode != SEQ_RESERVED);

  // Register writes
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      global_q  <= `CL_RESET_VALUE;
      seq_sel_q <= 4'h0;
      for (int t = 0; t < 2; t++) begin
        ctrl_a_q[t]  <= `CL_RESET_VALUE;
        ctrl_b_q[t]  <= `CL_RESET_VALUE;
        ctrl_c_q[t]  <= `CL_RESET_VALUE;
        pattern_q[t] <= `CL_RESET_VALUE;
      end
    end else if (WR_I) begin
      if (ADDR_I == `CL_OFF_GLOBAL) begin
        global_q <= WDATA_I & `CL_GLOBAL_MASK;
      end
      if (!glob_en) begin
        if (ADDR_I == `CL_OFF_SEQ) begin
          seq_sel_q <= 4'(WDATA_I & `CL_SEQ_MASK);
        end
        for (int t = 0; t < 2; t++) begin
          if (ADDR_I == table_addr(1'(t), `CL_SUB_A)) begin
            ctrl_a_q[t] <= WDATA_I & `CL_CTRL_A_MASK;
          end
          if (ADDR_I == table_addr(1'(t), `CL_SUB_B)) begin
            ctrl_b_q[t] <= WDATA_I;
          end
          if (ADDR_I == table_addr(1'(t), `CL_SUB_C)) begin
            ctrl_c_q[t] <= WDATA_I & `CL_CTRL_C_MASK;
          end
          if (ADDR_I == table_addr(1'(t), `CL_SUB_PATTERN)) begin
            pattern_q[t] <= WDATA_I;
          end
        end
      end
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
      if (RD_I) begin
        if (ADDR_I == `CL_OFF_GLOBAL) rdata_q <= global_q;
        if (ADDR_I == `CL_OFF_SEQ) rdata_q <= {4'h0, seq_sel_q};
        for (int t = 0; t < 2; t++) begin
          if (ADDR_I == table_addr(1'(t), `CL_SUB_A)) rdata_q <= ctrl_a_q[t];
          if (ADDR_I == table_addr(1'(t), `CL_SUB_B)) rdata_q <= ctrl_b_q[t];
          if (ADDR_I == table_addr(1'(t), `CL_SUB_C)) rdata_q <= ctrl_c_q[t];
          if (ADDR_I == table_addr(1'(t), `CL_SUB_PATTERN)) rdata_q <= pattern_q[t];
        end
      end
    end
  end

  assign RDATA_O = rdata_q;

  // Field decode and source selection
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      tab_en[t]  = glob_en & ctrl_a_q[t][`CL_BIT_ENABLE];
      clock_source_select[t]  = ctrl_a_q[t][`CL_BIT_CLOCK_SOURCE_SELECT];
      edge_en[t] = ctrl_a_q[t][`CL_BIT_EDGE];
      fmode[t]   = filt_decode(ctrl_a_q[t][`CL_FILT_HI:`CL_FILT_LO]);
      sel[t][0]  = ctrl_b_q[t][`CL_SEL0_HI:`CL_SEL0_LO];
      sel[t][1]  = ctrl_b_q[t][`CL_SEL1_HI:`CL_SEL1_LO];
      sel[t][2]  = ctrl_c_q[t][3:0];
      for (int i = 0; i < 3; i++) begin
        src_v[t][i] = 16'h0000;
        src_v[t][i][`CL_SRC_MASK]       = 1'b0;
        // Registered feedback keeps a transparent latch out of a loop
        src_v[t][i][`CL_SRC_FEEDBACK]   = seq_q & glob_en & ctrl_a_q[0][`CL_BIT_ENABLE];
        src_v[t][i][`CL_SRC_LINK]       = direct_q[1 - t];
        src_v[t][i][`CL_SRC_EVENT_LINE_0]     = EVENT_LINE_0_I;
        src_v[t][i][`CL_SRC_EVENT_LINE_1]     = EVENT_LINE_1_I;
        src_v[t][i][`CL_SRC_PIN]        = (t == 0) ? TABLE0_PIN_I[i] : TABLE1_PIN_I[i];
        src_v[t][i][`CL_SRC_COMPARATOR] = COMPARATOR_OUTPUT_I;
        src_v[t][i][`CL_SRC_TIMER_B]    = TIMER_B_OUTPUT_I;
        src_v[t][i][`CL_SRC_TIMER_A]    = TIMER_A_OUTPUT_I[i];
        src_v[t][i][`CL_SRC_TIMER_D]    = (i == 1) ? TIMER_D_OUTPUT_B_I : TIMER_D_OUTPUT_A_I;
      end
      src_v[t][0][`CL_SRC_SERIAL] = USART_CLOCK_I;
      src_v[t][0][`CL_SRC_SPI]    = SPI_SCK_I;
      src_v[t][1][`CL_SRC_SERIAL] = SERIAL_PORT_TXD_I;
      src_v[t][1][`CL_SRC_SPI]    = SPI_MOSI_I;
      src_v[t][2][`CL_SRC_SERIAL] = 1'b0;
      src_v[t][2][`CL_SRC_SPI]    = SPI_MISO_I;
      in_v[t][0] = pick(src_v[t][0], sel[t][0]);
      in_v[t][1] = pick(src_v[t][1], sel[t][1]);
      in_v[t][2] = pick(src_v[t][2], sel[t][2]) & ~clock_source_select[t];
      direct[t]  = pattern_q[t][in_v[t]];
    end
  end

  // Clock enables: line 2 rising edge or the peripheral clock
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      in2_prev_q <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        in2_prev_q[t] <= pick(src_v[t][2], sel[t][2]);
      end
    end
  end

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      if (clock_source_select[t]) begin
        tick[t] = pick(src_v[t][2], sel[t][2]) & ~in2_prev_q[t];
      end else begin
        tick[t] = peripheral_clock_run;
      end
    end
  end

  // Registered direct outputs break the link loop between tables
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      direct_q <= 2'b00;
    end else begin
      direct_q <= direct & tab_en;
    end
  end

  // Resync and glitch filter, cleared one cycle after disable
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sync1_q <= 2'b00;
      sync2_q <= 2'b00;
      hist0_q <= 2'b00;
      hist1_q <= 2'b00;
      filt_q  <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (!tab_en[t]) begin
          sync1_q[t] <= 1'b0;
          sync2_q[t] <= 1'b0;
          hist0_q[t] <= 1'b0;
          hist1_q[t] <= 1'b0;
          filt_q[t]  <= 1'b0;
        end else if (tick[t]) begin
          sync1_q[t] <= direct[t];
          sync2_q[t] <= sync1_q[t];
          hist0_q[t] <= sync2_q[t];
          hist1_q[t] <= hist0_q[t];
          if ((sync2_q[t] == hist0_q[t]) && (hist0_q[t] == hist1_q[t])) begin
            filt_q[t] <= sync2_q[t];
          end
        end
      end
    end
  end

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      unique case (fmode[t])
        FILT_NONE:     filt_out[t] = direct[t];
        FILT_SYNC:     filt_out[t] = sync2_q[t];
        FILT_FULL:     filt_out[t] = filt_q[t];
        FILT_RESERVED: filt_out[t] = direct[t];
      endcase
    end
  end

  // Rising-edge pulse detector
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      edge_prev_q <= 2'b00;
      edge_q      <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (!tab_en[t]) begin
          edge_prev_q[t] <= 1'b0;
          edge_q[t]      <= 1'b0;
        end else if (tick[t]) begin
          edge_prev_q[t] <= filt_out[t];
          edge_q[t]      <= filt_out[t] & ~edge_prev_q[t];
        end
      end
    end
  end

  assign stage = (edge_en & edge_q) | (~edge_en & filt_out);

  // Sequential element on the even table's clock
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      seq_hold_q <= 1'b1;
    end else begin
      seq_hold_q <= ~tab_en[0];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      seq_q <= 1'b0;
    end else if (!tab_en[0] || seq_hold_q) begin
      seq_q <= 1'b0;
    end else if (tick[0]) begin
      unique case (smode)
        SEQ_DFF: begin
          if (stage[1]) seq_q <= stage[0];
        end
        SEQ_JK: begin
          if (stage[0] && stage[1]) seq_q <= ~seq_q;
          else if (stage[0]) seq_q <= 1'b1;
          else if (stage[1]) seq_q <= 1'b0;
        end
        SEQ_DLATCH: begin
          if (stage[1]) seq_q <= stage[0];
        end
        SEQ_RS: begin
          if (stage[0] && !stage[1]) seq_q <= 1'b1;
          else if (stage[1] && !stage[0]) seq_q <= 1'b0;
        end
        default: seq_q <= 1'b0;
      endcase
    end
  end

  // Latch is transparent while its gate is high on a table 0 clock tick; disable clears at once
  always_comb begin
    if (!tab_en[0]) begin
      seq_val = 1'b0;
    end else if (smode == SEQ_DLATCH && stage[1] && tick[0]) begin
      seq_val = stage[0];
    end else begin
      seq_val = seq_q;
    end
  end

  // Final result with standby forcing
  always_comb begin
    result[0] = seq_on ? seq_val : stage[0];
    result[1] = stage[1];
    for (int t = 0; t < 2; t++) begin
      if (!tab_en[t]) begin
        result[t] = 1'b0;
      end else if (standby_off &&
                   ((((fmode[t] != FILT_NONE) || edge_en[t]) && !clock_source_select[t]) ||
                    (seq_on && !clock_source_select[0]))) begin
        result[t] = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      out_q <= 2'b00;
    end else begin
      out_q <= result;
    end
  end

  assign TABLE_OUT_O      = out_q;
  assign LUT_PIN_OUTPUT_O = out_q;
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      LUT_PIN_OE_O[t] = tab_en[t] & ctrl_a_q[t][`CL_BIT_PIN_OUTPUT_ENABLE];
    end
  end

  // SPI and serial sources are meaningful only with those ports as masters

endmodule

// *** tb/periph_model.sv ***
`timescale 1ns/1ps
module periph_model (
  // Clock and commanded levels
  input  wire logic        clk_i,
  input  wire logic [19:0] drive_i,
  // Source lines toward the block
  output logic      [19:0] src_o
);
  logic [19:0] lines = 20'h00000;
  // Lines change just after an edge; serial and SPI act as masters
  always @(posedge clk_i) begin
    lines <= drive_i;
  end
  assign src_o = lines;
endmodule

// *** tb/configurable_logic_props.sv ***
`timescale 1ns/1ps
module configurable_logic_props (
  input wire logic       CORE_CLK_I,
  input wire logic       RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       SLEEP_STANDBY_I,
  input wire logic [1:0] TABLE_OUT_O,
  input wire logic [1:0] LUT_PIN_OUTPUT_O,
  input wire logic [1:0] LUT_PIN_OE_O
);
  logic [7:0] sh_q [16];
  logic [7:0] exp_q;
  logic       en;
  logic       edg;
  logic       stb;
  function automatic logic [7:0] wmask(input logic [3:0] a);
    case (a)
      4'h0: return 8'h41;
      4'h1, 4'h7, 4'hb: return 8'h0f;
      4'h5, 4'h9: return 8'hf9;
      4'h6, 4'h8, 4'ha, 4'hc: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  // Shadow of the register file, protected writes dropped while enabled
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < 16; i++) sh_q[i] <= 8'h00;
    end else if (WR_I && (ADDR_I == 4'h0 || !sh_q[0][0])) begin
      sh_q[ADDR_I] <= WDATA_I & wmask(ADDR_I);
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    exp_q <= (RD_I && !RST_I) ? sh_q[ADDR_I] : 8'h00;
  end
  assign en = sh_q[0][0];
  assign edg = en & sh_q[5][0] & sh_q[5][7] & !sh_q[5][6] & (sh_q[1][3:0] == 4'h0) & !SLEEP_STANDBY_I;
  assign stb = SLEEP_STANDBY_I & !sh_q[0][6] & en & sh_q[5][0] & !sh_q[5][6]
             & (sh_q[5][7] | (sh_q[5][5:4] == 2'h1) | (sh_q[5][5:4] == 2'h2));
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  a_read_global: assert property ($past(RD_I) && $past(ADDR_I) == 4'h0 |-> RDATA_O == exp_q)
    else $error("global read wrong");
  a_read_table: assert property ($past(RD_I) && $past(ADDR_I) != 4'h0 |-> RDATA_O == exp_q)
    else $error("table read wrong");
  a_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not cleared");
  a_oe_formula: assert property (LUT_PIN_OE_O == {en & sh_q[9][0] & sh_q[9][3], en & sh_q[5][0] & sh_q[5][3]})
    else $error("pin enable wrong");
  a_pin_mirror: assert property (LUT_PIN_OUTPUT_O == TABLE_OUT_O)
    else $error("pin value differs");
  a_off_zero: assert property ((!en)[*3] |-> TABLE_OUT_O == 2'b00)
    else $error("output while disabled");
  a_edge_pulse: assert property (edg && $rose(TABLE_OUT_O[0]) |=> !TABLE_OUT_O[0])
    else $error("edge pulse too long");
  a_standby_zero: assert property (stb[*2] |-> !TABLE_OUT_O[0])
    else $error("standby output not forced");
endmodule
bind configurable_logic configurable_logic_props i_props (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SLEEP_STANDBY_I(SLEEP_STANDBY_I),
  .TABLE_OUT_O(TABLE_OUT_O), .LUT_PIN_OUTPUT_O(LUT_PIN_OUTPUT_O), .LUT_PIN_OE_O(LUT_PIN_OE_O));

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        clk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic        stby;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [19:0] drv;
  logic [19:0] src;
  logic [1:0]  tout;
  logic [1:0]  poe;
  logic [11:0] s;
  logic [7:0]  pats [3];
  int          err_count;
  int          n_checks;
  int          n;
  int          l0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  periph_model i_peri (.clk_i(clk), .drive_i(drv), .src_o(src));
  configurable_logic i_dut (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SLEEP_STANDBY_I(stby), .EVENT_LINE_0_I(src[0]), .EVENT_LINE_1_I(src[1]),
    .TABLE0_PIN_I(src[4:2]), .TABLE1_PIN_I(src[19:17]), .COMPARATOR_OUTPUT_I(src[5]), .TIMER_B_OUTPUT_I(src[6]),
    .TIMER_A_OUTPUT_I(src[9:7]), .TIMER_D_OUTPUT_A_I(src[10]), .TIMER_D_OUTPUT_B_I(src[11]),
    .SERIAL_PORT_TXD_I(src[12]), .USART_CLOCK_I(src[13]), .SPI_SCK_I(src[14]), .SPI_MOSI_I(src[15]),
    .SPI_MISO_I(src[16]), .TABLE_OUT_O(tout), .LUT_PIN_OUTPUT_O(), .LUT_PIN_OE_O(poe));
  function automatic logic [7:0] mask(int a);
    case (a)
      0: return 8'h41;
      1, 7, 11: return 8'h0f;
      5, 9: return 8'hf9;
      6, 8, 10, 12: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  function automatic int src_of(int code, int idx);
    case (code)
      3: return 0;
      4: return 1;
      5: return 2 + idx;
      6: return 5;
      7: return 6;
      8: return 7 + idx;
      9: return (idx == 1) ? 11 : 10;
      10: return (idx == 0) ? 13 : 12;
      default: return 14 + idx;
    endcase
  endfunction
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic cfg(logic [3:0] t, logic [7:0] sq, logic [7:0] a, logic [7:0] b, logic [7:0] c, logic [7:0] p);
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, sq);
    wr_reg(4'h5 + t, a);
    wr_reg(4'h6 + t, b);
    wr_reg(4'h7 + t, c);
    wr_reg(4'h8 + t, p);
    wr_reg(4'h0, 8'h01);
  endtask
  task automatic probe(logic [19:0] v, logic e);
    @(posedge clk);
    drv <= v;
    tick(6);
    `CHK(tout[0], e)
    @(posedge clk);
    drv <= 20'h00000;
    tick(6);
    `CHK(tout[0], 1'b0)
  endtask
  task automatic lat(output int k);
    @(posedge clk);
    drv[0] <= 1'b1;
    #1;
    k = 0;
    while (tout[0] !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    @(posedge clk);
    drv[0] <= 1'b0;
    tick(10);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    {rst, wr, rd, stby, addr, wdata, drv, err_count, n_checks} = '0;
    rst = 1'b1;
    pats = '{8'haa, 8'hcc, 8'hf0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd_reg(4'(a), 8'h00);
    for (int a = 15; a >= 0; a--) begin
      wr_reg(4'(a), 8'hff);
      rd_reg(4'(a), mask(a));
    end
    wr_reg(4'h8, 8'h00);
    rd_reg(4'h8, 8'hff);
    $display("test registers done");
    cfg(4'h0, 8'h00, 8'h09, 8'h55, 8'h05, 8'hb4);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      drv[4:2] <= 3'(i);
      tick(6);
      `CHK(tout[0], 1'((8'hb4 >> i) & 1))
      `CHK(poe, 2'b11)
    end
    $display("test index done");
    for (int idx = 0; idx < 3; idx++) begin
      for (int code = 0; code < 12; code++) begin
        if (code == 1 || code == 2 || (idx == 2 && code == 10)) continue;
        s = 12'(code) << (4 * idx);
        cfg(4'h0, 8'h00, 8'h01, s[7:0], {4'h0, s[11:8]}, pats[idx]);
        probe((code == 0) ? 20'hfffff : 20'h1 << src_of(code, idx), code != 0);
      end
    end
    $display("test sources done");
    cfg(4'h4, 8'h00, 8'h01, 8'h05, 8'h00, 8'haa);
    cfg(4'h0, 8'h00, 8'h01, 8'h02, 8'h00, 8'haa);
    probe(20'h20000, 1'b1);
    $display("test link done");
    for (int k = 0; k < 2; k++) begin
      cfg(4'h0, 8'h00, 8'h41, 8'h00, 8'h05, k ? 8'h0f : 8'hf0);
      repeat (4) begin
        @(posedge clk);
        drv[4] <= ~drv[4];
        tick(3);
      end
      `CHK(tout[0], 1'(k))
    end
    cfg(4'h0, 8'h00, 8'h51, 8'h03, 8'h05, 8'haa);
    @(posedge clk);
    drv[0] <= 1'b1;
    tick(6);
    `CHK(tout[0], 1'b0)
    repeat (2) begin
      @(posedge clk);
      drv[4] <= 1'b1;
      @(posedge clk);
      drv[4] <= 1'b0;
    end
    tick(6);
    `CHK(tout[0], 1'b1)
    @(posedge clk);
    drv <= 20'h00000;
    $display("test clock source done");
    cfg(4'h0, 8'h00, 8'h01, 8'h03, 8'h00, 8'haa);
    lat(l0);
    for (int f = 1; f < 3; f++) begin
      cfg(4'h0, 8'h00, 8'h01 | 8'(f << 4), 8'h03, 8'h00, 8'haa);
      lat(n);
      `CHK(n - l0 >= 2 && n - l0 <= 5, 1'b1)
    end
    cfg(4'h0, 8'h00, 8'h91, 8'h03, 8'h00, 8'haa);
    @(posedge clk);
    drv[0] <= 1'b1;
    n = 0;
    repeat (12) begin
      tick(1);
      n += (tout[0] === 1'b1);
    end
    `CHK(n, 1)
    @(posedge clk);
    drv[0] <= 1'b0;
    $display("test filter and edge done");
    cfg(4'h4, 8'h00, 8'h01, 8'h04, 8'h00, 8'haa);
    for (int m = 0; m < 5; m++) begin
      cfg(4'h0, 8'(m), 8'h01, 8'h03, 8'h00, 8'haa);
      for (int t = 0; t < 4; t++) begin
        @(posedge clk);
        drv[1:0] <= {t == 0 || t == 3 || (t == 1 && (m == 1 || m == 3)), t == 1};
        tick(6);
        `CHK(tout[0], t == 1 || (t == 2 && m != 0))
        `CHK(tout[1], t == 0 || t == 3 || (t == 1 && (m == 1 || m == 3)))
      end
    end
    @(posedge clk);
    drv <= 20'h00000;
    cfg(4'h0, 8'h01, 8'h01, 8'h01, 8'h00, 8'h55);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      drv[1] <= 1'b1;
      @(posedge clk);
      drv[1] <= 1'b0;
      tick(6);
      `CHK(tout[0], 1'(1 - t))
    end
    $display("test sequencer done");
    cfg(4'h0, 8'h00, 8'h11, 8'h03, 8'h00, 8'haa);
    @(posedge clk);
    drv <= 20'h00001;
    stby <= 1'b1;
    tick(8);
    `CHK(tout[0], 1'b0)
    wr_reg(4'h0, 8'h41);
    tick(8);
    `CHK(tout[0], 1'b1)
    cfg(4'h0, 8'h00, 8'h01, 8'h03, 8'h00, 8'haa);
    tick(8);
    `CHK(tout[0], 1'b1)
    @(posedge clk);
    stby <= 1'b0;
    $display("test standby done");
    tally_and_finish();
  end
endmodule
